// *** dv/fws_flash_model.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "fws_params.svh"
module fws_flash_model
    import fws_pkg::*;
#(
    parameter int WIN_CYC = 150,
    parameter int PROG_CYC = 20,
    parameter int ERASE_CYC = 300,
    parameter int LIMIT_CYC = 40
)
(
    input wire logic aclk,
    input wire fws_flash_o_t fl,
    output logic [`FWS_DW-1:0] dq,
    output logic ready_busy_n_out
);
    typedef enum logic [2:0] {FM_READ, FM_PROG, FM_FAIL, FM_WIN, FM_ERASE, FM_SUSP} fws_mode_t;
    fws_mode_t mode_r = FM_READ;
    logic [15:0] mem [int];
    logic [127:0] sel_r = '0;
    logic [2:0] step_r = '0;
    logic [2:0] bank_r = '0;
    logic [15:0] pdata_r = '0;
    logic to_r = 1'b0;
    logic t1_r = 1'b0;
    logic t2_r = 1'b0;
    logic prev_we_r = 1'b1;
    logic prev_oe_r = 1'b1;
    int cnt_r = 0;
    int dead [$];
    initial dq = '0;
    assign ready_busy_n_out = !(mode_r inside {FM_PROG, FM_FAIL, FM_WIN, FM_ERASE});
    function automatic logic [15:0] arr(input logic [22:0] a);
        return mem.exists(int'(a)) ? mem[int'(a)] : 16'hFFFF;
    endfunction
    // Each status read advances DQ6 (not in suspend), and DQ2 only for a selected sector in erase or suspend, as the real part does
    function automatic logic [15:0] rd(input logic [22:0] a);
        logic [15:0] q;
        q = 16'h0000;
        if (mode_r == FM_READ || a[22:20] != bank_r) return arr(a);
        if (mode_r == FM_SUSP)
        begin
            if (!sel_r[a[22:16]]) return arr(a);
            t2_r = ~t2_r;
            return {8'h00, 1'b1, t1_r, 3'b000, t2_r, 2'b00};
        end
        t1_r = ~t1_r;
        q[6] = t1_r;
        if (mode_r == FM_PROG || mode_r == FM_FAIL)
        begin
            q[7] = ~pdata_r[7];
            q[5] = to_r;
        end
        else
        begin
            q[3] = (mode_r == FM_ERASE);
            if (sel_r[a[22:16]]) t2_r = ~t2_r;
        end
        q[2] = t2_r;
        return q;
    endfunction
    task automatic cmd(input logic [22:0] a, input logic [15:0] d);
        if (mode_r == FM_ERASE || mode_r == FM_WIN)
        begin
            if (d == `FWS_CMD_SUSPEND)
            begin
                mode_r = FM_SUSP;
                cnt_r = 0;
            end
            else if (mode_r == FM_WIN && d == `FWS_CMD_SECTOR)
            begin
                sel_r[a[22:16]] = 1'b1;
                cnt_r = WIN_CYC;
            end
            return;
        end
        if (d == `FWS_CMD_RESET)
        begin
            if (mode_r != FM_SUSP) mode_r = FM_READ;
            step_r = 3'h0;
            return;
        end
        case (step_r)
            3'h0: step_r = (d == `FWS_CMD_UNLOCK1 && a == `FWS_UNLOCK1_ADDR) ? 3'h1 : 3'h0;
            3'h1: step_r = (d == `FWS_CMD_UNLOCK2) ? 3'h2 : 3'h0;
            3'h2: step_r = (d == `FWS_CMD_PROG) ? 3'h6 : (d == `FWS_CMD_ERASE) ? 3'h3 : 3'h0;
            3'h3: step_r = (d == `FWS_CMD_UNLOCK1) ? 3'h4 : 3'h0;
            3'h4: step_r = (d == `FWS_CMD_UNLOCK2) ? 3'h5 : 3'h0;
            3'h5:
            begin
                step_r = 3'h0;
                bank_r = a[22:20];
                if (d == `FWS_CMD_SECTOR)
                begin
                    sel_r = '0;
                    sel_r[a[22:16]] = 1'b1;
                    mode_r = FM_WIN;
                    cnt_r = WIN_CYC;
                end
                else if (d == `FWS_CMD_CHIP)
                begin
                    sel_r = '1;
                    mode_r = FM_ERASE;
                    cnt_r = ERASE_CYC;
                end
            end
            default:
            begin
                step_r = 3'h0;
                bank_r = a[22:20];
                pdata_r = d;
                to_r = 1'b0;
                cnt_r = PROG_CYC;
                mode_r = FM_PROG;
                if ((d & ~arr(a)) != 16'h0000)
                begin
                    mode_r = FM_FAIL;
                    cnt_r = LIMIT_CYC;
                end
                else mem[int'(a)] = arr(a) & d;
            end
        endcase
    endtask
    always @(posedge aclk)
    begin
        if (!prev_we_r && fl.we_n && !fl.ce_n) cmd(fl.addr, fl.wdata);
        if (prev_oe_r && !fl.oe_n && !fl.ce_n) dq <= rd(fl.addr);
        else if (!prev_oe_r && fl.oe_n) dq <= ~dq;
        prev_we_r = fl.we_n;
        prev_oe_r = fl.oe_n;
        if (cnt_r > 0)
        begin
            cnt_r--;
            if (cnt_r == 0 && mode_r == FM_PROG) mode_r = FM_READ;
            if (cnt_r == 0 && mode_r == FM_FAIL) to_r = 1'b1;
            if (cnt_r == 0 && mode_r == FM_WIN)
            begin
                mode_r = FM_ERASE;
                cnt_r = ERASE_CYC;
            end
            else if (cnt_r == 0 && mode_r == FM_ERASE)
            begin
                foreach (mem[k]) if (sel_r[k[22:16]]) dead.push_back(k);
                foreach (dead[i]) mem.delete(dead[i]);
                dead.delete();
                mode_r = FM_READ;
            end
        end
    end
endmodule
`default_nettype wire

// *** dv/fws_host_bench.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "fws_params.svh"
module fws_host_bench
    import fws_pkg::*;
;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid, ready_busy_n_out;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic [15:0] dq, fl_data;
    fws_flash_o_t fl_o;
    int err_total = 0;
    int tests_run = 0;
    localparam logic [22:0] adr_a = 23'h010010;
    localparam logic [22:0] adr_b = 23'h020020;
    localparam logic [22:0] adr_c = 23'h030000;
    localparam logic [22:0] adr_d = 23'h400004;
    assign fl_data = fl_o.drive ? fl_o.wdata : dq;
    fws_host dut (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
        .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
        .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
        .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
        .fl_o(fl_o), .fl_data_i(fl_data), .ready_busy_n_out(ready_busy_n_out));
    fws_flash_model flash (.aclk(aclk), .fl(fl_o), .dq(dq), .ready_busy_n_out(ready_busy_n_out));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            err_total++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        @(posedge aclk);
        while (awready !== 1'b1 || bvalid !== 1'b1) @(posedge aclk);
        r = bresp;
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        bready <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        @(posedge aclk);
        while (arready !== 1'b1 || rvalid !== 1'b1) @(posedge aclk);
        d = rdata;
        r = rresp;
        arvalid <= 1'b0;
        rready <= 1'b0;
        @(posedge aclk);
    endtask
    // Polls the busy flag; a hang is cut by the watchdog
    task automatic run(input logic [2:0] op, input logic [22:0] a, input logic [15:0] d,
        output logic [31:0] st);
        logic [1:0] r;
        axw(`FWS_REG_ADDR, {9'h000, a}, r);
        axw(`FWS_REG_WDATA, {16'h0000, d}, r);
        axw(`FWS_REG_CTRL, {29'h0, op}, r);
        st = 32'h1;
        while (st[0] !== 1'b0) axr(`FWS_REG_STATUS, st, r);
    endtask
    task automatic frd(input logic [22:0] a, output logic [15:0] q);
        logic [31:0] d;
        logic [1:0] r;
        run(`FWS_OPC_READ, a, 16'h0000, d);
        axr(`FWS_REG_RDATA, d, r);
        q = d[15:0];
    endtask
    task automatic t_regs();
        logic [31:0] d;
        logic [1:0] r;
        axr(`FWS_REG_STATUS, d, r);
        chk(d, 32'h0000_0040);
        axw(`FWS_REG_ADDR, 32'h0012_3456, r);
        axr(`FWS_REG_ADDR, d, r);
        chk(d, 32'h0012_3456);
        axr(`FWS_REG_CTRL, d, r);
        chk(d, 32'h0);
        axw(8'h20, 32'h1, r);
        chk({30'h0, r}, {30'h0, `FWS_RESP_SLVERR});
        axr(8'h20, d, r);
        chk({r, d[29:0]}, {`FWS_RESP_SLVERR, 30'h0});
        $display("register test done");
    endtask
    task automatic t_prog();
        logic [31:0] st;
        logic [15:0] q;
        run(`FWS_OPC_PROG, adr_a, 16'h1234, st);
        chk({29'h0, st[2:0]}, 32'h2);
        run(`FWS_OPC_PROG, adr_d, 16'h5A5A, st);
        run(`FWS_OPC_PROG, adr_c, 16'h00FF, st);
        frd(adr_a, q);
        chk({16'h0, q}, 32'h1234);
        run(`FWS_OPC_PROG, adr_a, 16'hFFFF, st);
        chk({31'h0, st[2]}, 32'h1);
        frd(adr_a, q);
        chk({16'h0, q}, 32'h1234);
        $display("program test done");
    endtask
    task automatic t_serase();
        logic [31:0] st;
        logic [15:0] q;
        run(`FWS_OPC_PROG, adr_b, 16'h0000, st);
        run(`FWS_OPC_SERASE, adr_a, 16'h0000, st);
        chk({30'h0, st[3], st[0]}, 32'h0);
        run(`FWS_OPC_ADDERASE, adr_b, 16'h0000, st);
        chk({29'h0, st[5:3]}, 32'h0);
        chk({31'h0, st[6]}, 32'h0);
        run(`FWS_OPC_POLL, adr_a, 16'h0000, st);
        frd(adr_b, q);
        chk({16'h0, q}, 32'hFFFF);
        frd(adr_a, q);
        chk({16'h0, q}, 32'hFFFF);
        $display("sector erase test done");
    endtask
    task automatic t_refuse();
        logic [31:0] st;
        logic [15:0] q;
        run(`FWS_OPC_SERASE, adr_a, 16'h0000, st);
        repeat (200) @(posedge aclk);
        run(`FWS_OPC_ADDERASE, adr_c, 16'h0000, st);
        chk({31'h0, st[5]}, 32'h1);
        chk({31'h0, st[6]}, 32'h0);
        frd(adr_d, q);
        chk({16'h0, q}, 32'h5A5A);
        run(`FWS_OPC_POLL, adr_a, 16'h0000, st);
        chk({31'h0, st[6]}, 32'h1);
        frd(adr_c, q);
        chk({16'h0, q}, 32'h00FF);
        $display("refused erase test done");
    endtask
    task automatic t_chip_susp();
        logic [31:0] st;
        logic [15:0] q;
        run(`FWS_OPC_PROG, adr_a, 16'h0F0F, st);
        run(`FWS_OPC_CERASE, adr_a, 16'h0000, st);
        frd(adr_a, q);
        chk({16'h0, q}, 32'hFFFF);
        run(`FWS_OPC_PROG, adr_d, 16'h5A5A, st);
        run(`FWS_OPC_SERASE, adr_a, 16'h0000, st);
        run(`FWS_OPC_SUSPEND, adr_a, 16'h0000, st);
        chk({31'h0, st[6]}, 32'h1);
        frd(adr_a, q);
        chk({31'h0, q[7]}, 32'h1);
        frd(adr_d, q);
        chk({16'h0, q}, 32'h5A5A);
        run(`FWS_OPC_RESET, adr_a, 16'h0000, st);
        chk({29'h0, st[2:0]}, 32'h2);
        $display("chip erase and suspend test done");
    endtask
    initial
    begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end
    initial
    begin
        #(40 * 30000);
        err_total++;
        give_verdict();
    end
    initial
    begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
        awaddr = 8'h00;
        araddr = 8'h00;
        wdata = 32'h0;
        wstrb = 4'hF;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_regs();
        t_prog();
        t_serase();
        t_refuse();
        t_chip_susp();
        give_verdict();
    end
endmodule
`default_nettype wire

// *** rtl/fws_host.sv ***
// Our own choices: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/10ps
`default_nettype none
`include "fws_params.svh"
module fws_host
    import fws_pkg::*;
#(
    parameter int WE_CYC = `FWS_WE_CYC,
    parameter int OE_CYC = `FWS_OE_CYC,
    parameter int GAP_CYC = `FWS_GAP_CYC
)
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic awvalid,
    output logic awready,
    input wire logic [7:0] awaddr,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    input wire logic arvalid,
    output logic arready,
    input wire logic [7:0] araddr,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output fws_flash_o_t fl_o,
    input wire logic [`FWS_DW-1:0] fl_data_i,
    input wire logic ready_busy_n_out
);
    if (WE_CYC < 1 || WE_CYC > 16 || OE_CYC < 1 || OE_CYC > 16 || GAP_CYC < 1
        || GAP_CYC > 16)
    begin : g_bad_timing
        $error("fws_host: pulse counts must lie in 1..16");
    end
    fws_regs_t r;
    fws_regs_t n;
    fws_step_t step;
    logic toggled;
    logic win;
    function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] d,
        input logic [3:0] s);
        for (int i = 0; i < 4; i++)
            wmerge[i*8 +: 8] = s[i] ? d[i*8 +: 8] : old[i*8 +: 8];
    endfunction
    // Register index, 3'd7 for an unmapped offset
    function automatic logic [2:0] reg_sel(input logic [7:0] a);
        case (a)
            `FWS_REG_CTRL: reg_sel = 3'h0;
            `FWS_REG_ADDR: reg_sel = 3'h1;
            `FWS_REG_WDATA: reg_sel = 3'h2;
            `FWS_REG_STATUS: reg_sel = 3'h3;
            `FWS_REG_RDATA: reg_sel = 3'h4;
            default: reg_sel = 3'h7;
        endcase
    endfunction
    // Bus write for a given step of a command sequence
    function automatic fws_step_t seq_step(input fws_op_t op, input logic [2:0] idx,
        input logic [`FWS_AW-1:0] a, input logic [`FWS_DW-1:0] d);
        logic [2:0] pre;
        pre = (op == FWS_OP_PROG) ? 3'h3 : (op == FWS_OP_SERASE || op == FWS_OP_CERASE)
            ? 3'h5 : 3'h0;
        seq_step.addr = a;
        seq_step.data = `FWS_CMD_RESET;
        seq_step.last = 1'b1;
        if (idx < pre)
        begin
            seq_step.last = 1'b0;
            seq_step.addr = (idx == 3'h1 || idx == 3'h4) ? `FWS_UNLOCK2_ADDR : `FWS_UNLOCK1_ADDR;
            seq_step.data = (op == FWS_OP_PROG) ? `FWS_CMD_PROG : `FWS_CMD_ERASE;
            if (idx == 3'h0 || idx == 3'h3)
                seq_step.data = `FWS_CMD_UNLOCK1;
            if (idx == 3'h1 || idx == 3'h4)
                seq_step.data = `FWS_CMD_UNLOCK2;
        end
        else
        begin
            case (op)
                FWS_OP_PROG: seq_step.data = d;
                FWS_OP_SERASE, FWS_OP_ADDERASE: seq_step.data = `FWS_CMD_SECTOR;
                FWS_OP_CERASE:
                begin
                    seq_step.addr = `FWS_UNLOCK1_ADDR;
                    seq_step.data = `FWS_CMD_CHIP;
                end
                FWS_OP_SUSPEND: seq_step.data = `FWS_CMD_SUSPEND;
                default: seq_step.data = `FWS_CMD_RESET;
            endcase
        end
    endfunction
    always_comb
    begin
        n = r;
        step = seq_step(r.op, r.idx, r.addr, r.wdata);
        toggled = r.stat[`FWS_FIRST_TOGGLE_BIT] ^ r.prev[`FWS_FIRST_TOGGLE_BIT];
        win = r.stat[`FWS_ERASE_WINDOW_BIT];
        n.rb_level = ready_busy_n_out;
        n.awready = 1'b0;
        n.wready = 1'b0;
        n.arready = 1'b0;
        n.bvalid = r.bvalid && !bready;
        n.rvalid = r.rvalid && !rready;
        if (!r.bvalid && !r.awready && awvalid && wvalid)
        begin
            n.awready = 1'b1;
            n.wready = 1'b1;
            n.bvalid = 1'b1;
            n.bresp = `FWS_RESP_OKAY;
            case (reg_sel(awaddr))
                3'h0:
                    if (r.state != ST_IDLE || !wstrb[0])
                        n.bresp = `FWS_RESP_SLVERR;
                    else
                    begin
                        n.state = ST_NEXT;
                        n.idx = 3'h0;
                        n.primed = 1'b0;
                        n.timeout_seen = 1'b0;
                        n.done = 1'b0;
                        n.fail = 1'b0;
                        n.maybe_rej = 1'b0;
                        n.refused = 1'b0;
                        n.phase = PH_SEQ;
                        case (wdata[2:0])
                            `FWS_OPC_READ:
                            begin
                                n.op = FWS_OP_READ;
                                n.phase = PH_READ;
                            end
                            `FWS_OPC_PROG: n.op = FWS_OP_PROG;
                            `FWS_OPC_SERASE: n.op = FWS_OP_SERASE;
                            `FWS_OPC_CERASE: n.op = FWS_OP_CERASE;
                            `FWS_OPC_ADDERASE:
                            begin
                                n.op = FWS_OP_ADDERASE;
                                n.phase = PH_PRECHK;
                            end
                            `FWS_OPC_SUSPEND: n.op = FWS_OP_SUSPEND;
                            `FWS_OPC_RESET: n.op = FWS_OP_RESET;
                            default:
                            begin
                                n.op = FWS_OP_POLL;
                                n.phase = PH_POLL;
                            end
                        endcase
                    end
                3'h1: n.addr = `FWS_AW'(wmerge(32'(r.addr), wdata, wstrb));
                3'h2: n.wdata = `FWS_DW'(wmerge(32'(r.wdata), wdata, wstrb));
                3'h3, 3'h4: n.bresp = `FWS_RESP_OKAY;
                default: n.bresp = `FWS_RESP_SLVERR;
            endcase
        end
        if (!r.rvalid && !r.arready && arvalid)
        begin
            n.arready = 1'b1;
            n.rvalid = 1'b1;
            n.rresp = `FWS_RESP_OKAY;
            case (reg_sel(araddr))
                3'h1: n.rdata_bus = 32'(r.addr);
                3'h2: n.rdata_bus = 32'(r.wdata);
                3'h3:
                begin
                    n.rdata_bus = {r.stat, 9'h000, r.rb_level, r.refused, r.maybe_rej,
                        r.window_closed, r.fail, r.done, r.state != ST_IDLE};
                end
                3'h4: n.rdata_bus = 32'(r.rdata);
                3'h0: n.rdata_bus = 32'h00000000;
                default:
                begin
                    n.rdata_bus = 32'h00000000;
                    n.rresp = `FWS_RESP_SLVERR;
                end
            endcase
        end
        case (r.state)
            ST_NEXT:
            begin
                n.fl.ce_n = 1'b0;
                if (r.phase == PH_SEQ)
                begin
                    n.fl.addr = step.addr;
                    n.fl.wdata = step.data;
                    n.fl.drive = 1'b1;
                    n.fl.we_n = 1'b0;
                    n.cnt = 4'(WE_CYC - 1);
                    n.state = ST_BUS_WR;
                end
                else
                begin
                    // Status only comes back from the busy bank; DQ2 toggles only in a selected sector
                    n.fl.addr = r.addr;
                    n.fl.oe_n = 1'b0;
                    n.cnt = 4'(OE_CYC - 1);
                    n.state = ST_BUS_RD;
                end
            end
            ST_BUS_WR:
                if (r.cnt != 4'h0)
                    n.cnt = r.cnt - 4'h1;
                else if (!r.fl.we_n)
                begin
                    n.fl.we_n = 1'b1;
                    n.cnt = 4'(GAP_CYC - 1);
                end
                else
                begin
                    n.fl.ce_n = 1'b1;
                    n.fl.drive = 1'b0;
                    n.state = ST_NEXT;
                    n.idx = r.idx + 3'h1;
                    if (step.last)
                    begin
                        n.idx = 3'h0;
                        n.primed = 1'b0;
                        case (r.op)
                            FWS_OP_SERASE: n.phase = PH_ACCEPT;
                            FWS_OP_ADDERASE: n.phase = PH_WINDOW;
                            FWS_OP_RESET: n.state = ST_IDLE;
                            default: n.phase = PH_POLL;
                        endcase
                    end
                end
            ST_BUS_RD:
                if (r.cnt != 4'h0)
                    n.cnt = r.cnt - 4'h1;
                else if (!r.fl.oe_n)
                begin
                    n.fl.oe_n = 1'b1;
                    n.stat = fl_data_i;
                    n.cnt = 4'(GAP_CYC - 1);
                end
                else
                begin
                    n.fl.ce_n = 1'b1;
                    n.state = ST_NEXT;
                    n.primed = 1'b1;
                    n.prev = r.stat;
                    case (r.phase)
                        PH_PRECHK:
                            if (win)
                            begin
                                n.refused = 1'b1;
                                n.window_closed = 1'b1;
                                n.state = ST_IDLE;
                            end
                            else
                                n.phase = PH_SEQ;
                        PH_ACCEPT:
                            if (r.primed && toggled)
                            begin
                                n.phase = PH_WINDOW;
                                n.primed = 1'b0;
                            end
                            else if (r.primed)
                                n.state = ST_IDLE;
                        PH_WINDOW:
                        begin
                            n.window_closed = win;
                            n.maybe_rej = win && r.op == FWS_OP_ADDERASE;
                            n.state = ST_IDLE;
                        end
                        PH_POLL:
                            if (r.primed && !toggled)
                                n.state = ST_IDLE;
                            else if (r.primed && r.stat[`FWS_TIMEOUT_FAILURE_BIT])
                            begin
                                // Toggle is checked once more after the failure bit shows
                                if (r.timeout_seen)
                                begin
                                    n.fail = 1'b1;
                                    n.op = FWS_OP_RESET;
                                    n.phase = PH_SEQ;
                                    n.idx = 3'h0;
                                end
                                n.timeout_seen = 1'b1;
                            end
                        default:
                        begin
                            n.rdata = r.stat;
                            n.state = ST_IDLE;
                        end
                    endcase
                end
            default: n.cnt = 4'h0;
        endcase
        if (r.state != ST_IDLE && n.state == ST_IDLE)
            n.done = 1'b1;
        if (!aresetn)
        begin
            n = '0;
            n.fl.ce_n = 1'b1;
            n.fl.oe_n = 1'b1;
            n.fl.we_n = 1'b1;
        end
    end
    always_ff @(posedge aclk)
        r <= n;
    assign awready = r.awready;
    assign wready = r.wready;
    assign bvalid = r.bvalid;
    assign bresp = r.bresp;
    assign arready = r.arready;
    assign rvalid = r.rvalid;
    assign rdata = r.rdata_bus;
    assign rresp = r.rresp;
    assign fl_o = r.fl;
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    sequence s_add_wr_end;
        r.op == FWS_OP_ADDERASE && $rose(r.fl.we_n);
    endsequence
    sequence s_window_read;
        r.phase == PH_WINDOW && !r.fl.oe_n;
    endsequence
    chk_fail_reset: assert property ($rose(r.fail) |-> ##[1:40]
        (!r.fl.we_n && r.fl.wdata == `FWS_CMD_RESET && r.fl.addr == r.addr))
        else $error("reset command not issued after timeout failure");
    chk_bank_addr: assert property ((!r.fl.oe_n) |->
        (r.fl.addr == r.addr && !r.fl.drive && !r.fl.ce_n))
        else $error("status read outside target bank");
    chk_poll_addr: assert property ((r.phase == PH_POLL && $fell(r.fl.oe_n)) |->
        $stable(r.addr) && r.fl.addr == r.addr)
        else $error("poll read at wrong address");
    chk_pre_check: assert property ((r.op == FWS_OP_ADDERASE && $fell(r.fl.we_n)) |->
        !r.stat[`FWS_ERASE_WINDOW_BIT])
        else $error("sector added without open window check");
    chk_post_check: assert property (s_add_wr_end |-> ##[1:40] s_window_read)
        else $error("window not rechecked after added sector");
    chk_rej_flag: assert property ($rose(r.maybe_rej) |->
        r.stat[`FWS_ERASE_WINDOW_BIT] && r.op == FWS_OP_ADDERASE && $past(r.phase) == PH_WINDOW)
        else $error("reject flag without closed window");
endmodule
`default_nettype wire

// *** rtl/fws_params.svh ***
// Function
// - After timeout host writes reset to bank
// - Host checks window before and after adding
// - Status reads use busy bank address
// - Poll reads use programmed or erasing address
`ifndef FWS_PARAMS_SVH
`define FWS_PARAMS_SVH
`define FWS_AW 23
`define FWS_DW 16
`define FWS_CLK_NS 40
`define FWS_WE_LOW_NS 60
`define FWS_OE_LOW_NS 80
`define FWS_GAP_NS 40
`define FWS_WE_CYC ((`FWS_WE_LOW_NS + `FWS_CLK_NS - 1) / `FWS_CLK_NS)
`define FWS_OE_CYC ((`FWS_OE_LOW_NS + `FWS_CLK_NS - 1) / `FWS_CLK_NS)
`define FWS_GAP_CYC ((`FWS_GAP_NS + `FWS_CLK_NS - 1) / `FWS_CLK_NS)
`define FWS_REG_CTRL 8'h00
`define FWS_REG_ADDR 8'h04
`define FWS_REG_WDATA 8'h08
`define FWS_REG_STATUS 8'h0C
`define FWS_REG_RDATA 8'h10
`define FWS_OPC_READ 3'h1
`define FWS_OPC_PROG 3'h2
`define FWS_OPC_SERASE 3'h3
`define FWS_OPC_CERASE 3'h4
`define FWS_OPC_ADDERASE 3'h5
`define FWS_OPC_SUSPEND 3'h6
`define FWS_OPC_RESET 3'h7
`define FWS_OPC_POLL 3'h0
`define FWS_ST_BUSY 0
`define FWS_ST_DONE 1
`define FWS_ST_FAIL 2
`define FWS_ST_WINDOW 3
`define FWS_ST_MAYBE_REJ 4
`define FWS_ST_REFUSED 5
`define FWS_ST_RB 6
`define FWS_POLLING_BIT 7
`define FWS_FIRST_TOGGLE_BIT 6
`define FWS_TIMEOUT_FAILURE_BIT 5
`define FWS_ERASE_WINDOW_BIT 3
`define FWS_SECOND_TOGGLE_BIT 2
`define FWS_UNLOCK1_ADDR 23'h000555
`define FWS_UNLOCK2_ADDR 23'h0002AA
`define FWS_CMD_UNLOCK1 16'h00AA
`define FWS_CMD_UNLOCK2 16'h0055
`define FWS_CMD_PROG 16'h00A0
`define FWS_CMD_ERASE 16'h0080
`define FWS_CMD_SECTOR 16'h0030
`define FWS_CMD_CHIP 16'h0010
`define FWS_CMD_SUSPEND 16'h00B0
`define FWS_CMD_RESET 16'h00F0
`define FWS_RESP_OKAY 2'h0
`define FWS_RESP_SLVERR 2'h2
`endif

// *** rtl/fws_pkg.sv ***
`default_nettype none
`include "fws_params.svh"
package fws_pkg;
    typedef enum logic [3:0] {FWS_OP_READ, FWS_OP_PROG, FWS_OP_SERASE, FWS_OP_CERASE,
        FWS_OP_ADDERASE, FWS_OP_SUSPEND, FWS_OP_RESET, FWS_OP_POLL} fws_op_t;
    typedef enum logic [1:0] {ST_IDLE, ST_NEXT, ST_BUS_WR, ST_BUS_RD} fws_state_t;
    typedef enum logic [2:0] {PH_SEQ, PH_PRECHK, PH_ACCEPT, PH_WINDOW, PH_POLL,
        PH_READ} fws_phase_t;
    typedef struct packed {
        logic [`FWS_AW-1:0] addr;
        logic [`FWS_DW-1:0] data;
        logic last;
    } fws_step_t;
    typedef struct packed {
        logic [`FWS_AW-1:0] addr;
        logic [`FWS_DW-1:0] wdata;
        logic drive;
        logic ce_n;
        logic oe_n;
        logic we_n;
    } fws_flash_o_t;
    typedef struct packed {
        fws_state_t state;
        fws_phase_t phase;
        fws_op_t op;
        logic [2:0] idx;
        logic [3:0] cnt;
        logic primed;
        logic timeout_seen;
        logic [`FWS_DW-1:0] stat;
        logic [`FWS_DW-1:0] prev;
        fws_flash_o_t fl;
        logic [`FWS_AW-1:0] addr;
        logic [`FWS_DW-1:0] wdata;
        logic [`FWS_DW-1:0] rdata;
        logic done;
        logic fail;
        logic window_closed;
        logic maybe_rej;
        logic refused;
        logic rb_level;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata_bus;
    } fws_regs_t;
endpackage
`default_nettype wire
